// ### logic/umls_pkg.sv
// Constants and types for the modem, line status and baud block.
// Assumes a 32-bit APB slave with word-aligned byte registers.
package umls_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_DIV_LOW = 3'h0; // Divisor low, access bit set
  localparam logic [2:0] IDX_DIV_HIGH = 3'h1; // Divisor high, access bit set
  localparam logic [2:0] IDX_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] IDX_LINE_STATUS = 3'h5;
  localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
  localparam logic [2:0] IDX_SCRATCH = 3'h7;
  localparam int ADDR_LSB = 2; // Word index starts at address bit 2
  localparam int ADDR_W = 5; // Decoded address bits
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_TERM_READY = 0;
  localparam int MC_SEND_REQ = 1;
  localparam int MC_USER_ONE = 2;
  localparam int MC_IRQ_GATE = 3;
  localparam int MC_LOOP = 4;
  localparam logic [7:0] MC_MASK = 8'h1F; // Bits 5..7 read zero
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MC_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [4:0] PIN_IDLE = 5'h1F; // Pins idle high
  // ----------------------------------------------------------------
  // Baud generator figures
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_ZERO_AS = 16'h0003; // Zero divides by three
  localparam logic [15:0] DIV_ONE = 16'h0001;
  localparam logic [15:0] DIV_TWO = 16'h0002;
  localparam logic [15:0] LOW_CLOCKS = 16'h0002; // Low span for large divisors

  // Receiver events, one-cycle pulses from the receiver core
  typedef struct packed {
    logic overrun; // Overrun detected
    logic parity; // Parity error now visible
    logic framing; // Framing error now visible
    logic brk; // Break now visible
  } umls_rx_err_t;

  // Receiver and transmitter levels from the core
  typedef struct packed {
    logic fifo_mode; // FIFOs enabled
    logic rx_empty; // No received data held
    logic fifo_err_any; // Some error still inside the receive FIFO
    logic tx_hold_empty; // Holding register or transmit FIFO empty
    logic tx_shift_empty; // Transmit shift register empty
  } umls_core_t;
endpackage : umls_pkg

// ### logic/umls_top.sv
// Modem control, line status, modem status, scratch and baud generator.
// Assumes an APB master on pclk and a receiver/transmitter core on pclk
// that reports its events and levels through the packed structs.
//
// Summary of operation
// RULE1 - Control bits 0,1 drive ready/request pins inverted
// RULE2 - Control bit 2 is storage only; the code also uses it as the ring source in loopback
// RULE3 - Control bit 3 gates the interrupt output
// RULE4 - Loopback: line mark, internal data and modem paths
// RULE5 - Loopback modem interrupts sourced from control bits
// RULE6 - Control bits 5 to 7 read zero
// RULE7 - Data ready follows unread received data
// RULE8 - Overrun sets at once, clears on read
// RULE9 - Parity error sticky, clears on read
// RULE10 - Framing error sticky, clears on read
// RULE11 - Break flag sticky, clears on read
// RULE12 - Error bits raise line status interrupt
// RULE13 - Holding empty read-only, requests interrupt
// RULE14 - All empty when holding and shift empty
// RULE15 - Bit 7 flags errors inside the FIFO
// RULE16 - Modem input changes set bits, read clears
// RULE17 - Ring bit sets on ring input rising
// RULE18 - Status bits 4-7 show inverted modem inputs
// RULE19 - Scratch byte is plain storage
// RULE20 - Baud divider, 16-bit divisor, 16x output
// RULE21 - Divisor write reloads the baud counter
// RULE22 - Divisor 0,1,2 and larger give set waveforms
// RULE23 - Software sets access bit for divisor latches
// RULE24 - Read-clear returns old value, keeps new events
//
// The implementer's own choice: the APB slave port.
module umls_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic divisor_access_bit, // From line control, outside
  input wire logic ier_line_en, // Line status interrupt enable
  input wire logic ier_modem_en, // Modem status interrupt enable
  input wire logic core_irq, // Receive/transmit interrupt request
  input wire umls_pkg::umls_rx_err_t rx_err, // Receiver event pulses
  input wire umls_pkg::umls_core_t core_st, // Core levels
  input wire logic tx_shift_out, // Transmit shift register output
  output logic rx_shift_in, // Receive shift register input
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  input wire logic clear_to_send_in_n,
  input wire logic set_ready_in_n,
  input wire logic ring_in_n,
  input wire logic carrier_detect_in_n,
  output logic terminal_ready_out_n,
  output logic send_request_out_n,
  output logic uart_irq,
  output logic uart_irq_oe,
  output logic line_status_irq,
  output logic modem_status_irq,
  output logic baud_tick, // One pulse per 16x period
  output logic baud_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_raw; // {rx, dcd, ri, dsr, cts}
  logic [4:0] s1_q; // First stage, read only by s2
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  logic [4:0] pin_q; // Filtered pin levels

  assign pin_raw = {serial_rx_line, carrier_detect_in_n, ring_in_n,
                    set_ready_in_n, clear_to_send_in_n};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      // Three stages, change taken when stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi] <= umls_pkg::PIN_IDLE[gi];
          s2_q[gi] <= umls_pkg::PIN_IDLE[gi];
          s3_q[gi] <= umls_pkg::PIN_IDLE[gi];
          pin_q[gi] <= umls_pkg::PIN_IDLE[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [2:0] idx; // Word index
  logic hit_dl; // Divisor latches
  logic mapped; // Address belongs to this block
  logic setup; // Setup phase
  logic access; // Completing access phase
  logic wr_en;
  logic rd_en;

  assign idx = paddr[umls_pkg::ADDR_LSB +: 3];
  assign hit_dl = divisor_access_bit &&
                  (idx == umls_pkg::IDX_DIV_LOW || idx == umls_pkg::IDX_DIV_HIGH);
  assign mapped = (paddr[31:umls_pkg::ADDR_W] == '0) && (paddr[1:0] == 2'h0) &&
                  (hit_dl || idx >= umls_pkg::IDX_MODEM_CONTROL);
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && mapped;
  assign rd_en = access && !pwrite && mapped;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  logic [7:0] mc_q; // Modem control
  logic [7:0] scratch_q;
  logic [15:0] div_q;
  logic div_wr; // Divisor latch written

  assign div_wr = wr_en && hit_dl;

  // Modem control, five live bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= umls_pkg::MC_RESET;
    end else if (wr_en && idx == umls_pkg::IDX_MODEM_CONTROL) begin
      mc_q <= pwdata[7:0] & umls_pkg::MC_MASK; // RULE2 RULE6
    end
  end

  // Scratch byte, no effect elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_q <= umls_pkg::SCRATCH_RESET;
    end else if (wr_en && idx == umls_pkg::IDX_SCRATCH) begin
      scratch_q <= pwdata[7:0]; // RULE19
    end
  end

  // Divisor latches, reached only with access bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= umls_pkg::DIV_RESET;
    end else if (div_wr) begin // RULE23
      if (idx == umls_pkg::IDX_DIV_LOW) begin
        div_q[7:0] <= pwdata[7:0];
      end else begin
        div_q[15:8] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Modem signal routing
  // ----------------------------------------------------------------
  logic loop; // Loopback mode
  logic [3:0] modem_act; // Active-high {dcd, ri, dsr, cts}
  logic [3:0] modem_prev_q; // Previous levels for change detect

  assign loop = mc_q[umls_pkg::MC_LOOP];
  // Loopback swaps pins for control bits
  assign modem_act = loop ? {mc_q[umls_pkg::MC_IRQ_GATE], mc_q[umls_pkg::MC_USER_ONE],
                             mc_q[umls_pkg::MC_TERM_READY], mc_q[umls_pkg::MC_SEND_REQ]}
                          : ~pin_q[3:0]; // RULE4 RULE5 RULE18

  // Previous modem levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_prev_q <= 4'h0;
    end else begin
      modem_prev_q <= modem_act;
    end
  end

  // Output pins forced inactive in loopback; rx_shift_in takes tx_shift_out in loopback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_ready_out_n <= 1'b1;
      send_request_out_n <= 1'b1;
      serial_tx_line <= 1'b1;
      rx_shift_in <= 1'b1;
    end else begin
      terminal_ready_out_n <= loop || !mc_q[umls_pkg::MC_TERM_READY]; // RULE1 RULE4
      send_request_out_n <= loop || !mc_q[umls_pkg::MC_SEND_REQ]; // RULE1 RULE4
      serial_tx_line <= loop || tx_shift_out; // RULE4
      rx_shift_in <= loop ? tx_shift_out : pin_q[4]; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Sticky status flags
  // ----------------------------------------------------------------
  logic [3:0] modem_chg; // This cycle's change events
  logic [3:0] msr_chg_q; // {dcd, ri edge, dsr, cts}
  logic [3:0] lsr_err_q; // {break, framing, parity, overrun}
  logic [3:0] lsr_set;
  logic fifo_err_q; // Bit 7
  logic [31:0] rd_val_q; // Value returned by the current read
  logic lsr_rd;
  logic msr_rd;

  assign lsr_rd = rd_en && idx == umls_pkg::IDX_LINE_STATUS;
  assign msr_rd = rd_en && idx == umls_pkg::IDX_MODEM_STATUS;

  // Changes on cts, dsr, dcd; ring active falling is pin rising
  assign modem_chg[0] = modem_act[0] ^ modem_prev_q[0]; // RULE16
  assign modem_chg[1] = modem_act[1] ^ modem_prev_q[1]; // RULE16
  assign modem_chg[2] = modem_prev_q[2] && !modem_act[2]; // RULE17
  assign modem_chg[3] = modem_act[3] ^ modem_prev_q[3]; // RULE16

  // Error events from the receiver core; it times FIFO-top visibility
  assign lsr_set = {rx_err.brk, rx_err.framing, rx_err.parity,
                    rx_err.overrun}; // RULE8 RULE9 RULE10 RULE11

  // Modem change bits, clear only what was returned, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_chg_q <= 4'h0;
    end else begin
      msr_chg_q <= (msr_chg_q & ~({4{msr_rd}} & rd_val_q[3:0])) | modem_chg; // RULE16 RULE24
    end
  end

  // Line error bits, clear only what was returned, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsr_err_q <= 4'h0;
    end else begin
      lsr_err_q <= (lsr_err_q & ~({4{lsr_rd}} & rd_val_q[4:1])) | lsr_set; // RULE8 RULE24
    end
  end

  // FIFO error summary, cleared by read only if FIFO holds none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_err_q <= 1'b0;
    end else if (!core_st.fifo_mode) begin
      fifo_err_q <= 1'b0; // RULE15
    end else if (core_st.fifo_err_any || lsr_set[3:1] != 3'h0) begin
      fifo_err_q <= 1'b1; // RULE15
    end else if (lsr_rd) begin
      fifo_err_q <= 1'b0; // RULE15
    end
  end

  // ----------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [7:0] rd_mux;

  assign lsr_val = {fifo_err_q, // RULE15
                    core_st.tx_hold_empty && core_st.tx_shift_empty, // RULE14
                    core_st.tx_hold_empty, // RULE13
                    lsr_err_q, // RULE9 RULE10 RULE11
                    !core_st.rx_empty}; // RULE7
  assign msr_val = {modem_act, msr_chg_q}; // RULE18

  // Read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    if (hit_dl) begin
      rd_mux = (idx == umls_pkg::IDX_DIV_LOW) ? div_q[7:0] : div_q[15:8];
    end else begin
      case (idx)
        umls_pkg::IDX_MODEM_CONTROL: rd_mux = mc_q; // RULE6
        umls_pkg::IDX_LINE_STATUS: rd_mux = lsr_val;
        umls_pkg::IDX_MODEM_STATUS: rd_mux = msr_val;
        umls_pkg::IDX_SCRATCH: rd_mux = scratch_q;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Answer one cycle after setup; data frozen at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_val_q <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      rd_val_q <= (mapped && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign prdata = rd_val_q;

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  // Line and modem requests, ungated total on uart_irq, gate bit drives uart_irq_oe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_status_irq <= 1'b0;
      modem_status_irq <= 1'b0;
      uart_irq <= 1'b0;
      uart_irq_oe <= 1'b0;
    end else begin
      line_status_irq <= ier_line_en && (lsr_err_q != 4'h0); // RULE12
      modem_status_irq <= ier_modem_en && (msr_chg_q != 4'h0); // RULE16 RULE5
      uart_irq <= core_irq || (ier_line_en && lsr_err_q != 4'h0) ||
                  (ier_modem_en && msr_chg_q != 4'h0); // RULE13
      uart_irq_oe <= mc_q[umls_pkg::MC_IRQ_GATE]; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic [15:0] div_eff; // Divisor with zero mapped to three
  logic [15:0] cnt_q; // Counts down from div_eff to one
  logic [15:0] div_new; // Divisor including this cycle's latch write

  assign div_eff = (div_q == 16'h0000) ? umls_pkg::DIV_ZERO_AS : div_q; // RULE22
  // Reload must use the byte being written, not the stale latch
  assign div_new = (idx == umls_pkg::IDX_DIV_LOW) ? {div_q[15:8], pwdata[7:0]}
                                                   : {pwdata[7:0], div_q[7:0]};

  // Counter reloads on divisor write and at end of count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= umls_pkg::DIV_ZERO_AS;
      baud_tick <= 1'b0;
    end else if (div_wr) begin
      cnt_q <= (div_new == 16'h0000) ? umls_pkg::DIV_ZERO_AS : div_new; // RULE21
      baud_tick <= 1'b0;
    end else if (cnt_q <= 16'h0001) begin
      cnt_q <= div_eff; // RULE20
      baud_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  // 16x output waveform
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_out <= 1'b1;
    end else if (div_eff == umls_pkg::DIV_ONE) begin
      baud_out <= !baud_out; // RULE22
    end else if (div_eff == umls_pkg::DIV_TWO) begin
      baud_out <= (cnt_q != umls_pkg::DIV_TWO); // RULE22
    end else begin
      baud_out <= (div_eff - cnt_q) >= umls_pkg::LOW_CLOCKS; // RULE22
    end
  end
endmodule : umls_top

// ### bench/umls_props.sv
// Checker for the modem control, line status and baud block.
// Assumes it is bound to umls_top and sees only that module's ports.
module umls_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic divisor_access_bit,
  input wire logic ier_line_en,
  input wire umls_pkg::umls_rx_err_t rx_err,
  input wire logic tx_shift_out,
  input wire logic rx_shift_in,
  input wire logic serial_tx_line,
  input wire logic terminal_ready_out_n,
  input wire logic send_request_out_n,
  input wire logic uart_irq_oe,
  input wire logic line_status_irq,
  input wire logic baud_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_q; // Shadow of modem control
  logic [15:0] dv_q; // Shadow of the divisor
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Shadow registers follow completed writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
      dv_q <= 16'h0000;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 32'h10) ctl_q <= pwdata[7:0];
      if (divisor_access_bit && paddr == 32'h0) dv_q[7:0] <= pwdata[7:0];
      if (divisor_access_bit && paddr == 32'h4) dv_q[15:8] <= pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  unmapped_err_a: assert property (pready && (paddr[1:0] != 2'h0 ||
    paddr[31:5] != 27'h0 || paddr[4:3] == 2'h1 || (paddr[4:3] == 2'h0 && !divisor_access_bit))
    |-> pslverr) else $error("unmapped access without error");
  ctl_read_a: assert property (pready && !pwrite && paddr == 32'h10
    |-> prdata == {27'h0, ctl_q[4:0]}) else $error("control readback wrong");
  pin_drive_a: assert property (ctl_q == $past(ctl_q) |->
    terminal_ready_out_n == (ctl_q[4] | !ctl_q[0]) && send_request_out_n == (ctl_q[4] | !ctl_q[1]))
    else $error("handshake pins disagree with control");
  irq_gate_a: assert property (ctl_q == $past(ctl_q) |-> uart_irq_oe == ctl_q[3])
    else $error("interrupt enable pin disagrees with gate bit");
  tx_mark_a: assert property (ctl_q[4] && $past(ctl_q[4]) |-> serial_tx_line)
    else $error("transmit line not at mark in loopback");
  loop_data_a: assert property (ctl_q[4] && $past(ctl_q[4])
    |-> rx_shift_in == $past(tx_shift_out)) else $error("loopback data path broken");
  tx_pass_a: assert property (!$past(ctl_q[4])
    |-> serial_tx_line == $past(tx_shift_out)) else $error("transmit line not following data");
  line_irq_a: assert property (ier_line_en && rx_err != 4'h0 |-> ##[1:2] line_status_irq)
    else $error("line status interrupt missing");
  baud_low_a: assert property ($fell(baud_out) && !psel && $stable(dv_q) && dv_q != 16'h0001
    && dv_q != 16'h0002 |=> !baud_out ##1 baud_out) else $error("baud low span not two clocks");
endmodule : umls_props

bind umls_top umls_props umls_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .divisor_access_bit, .ier_line_en, .rx_err, .tx_shift_out,
  .rx_shift_in, .serial_tx_line, .terminal_ready_out_n, .send_request_out_n, .uart_irq_oe,
  .line_status_irq, .baud_out);

// ### bench/umls_modem.sv
// Model of the modem on the far side: handshake lines and a line echo.
// Assumes the bench gives asserted levels; slow makes replies late.
module umls_modem (
  input wire logic pclk,
  input wire logic [3:0] lines, // Asserted {carrier, ring, ready, clear}
  input wire logic slow, // Late replies when high
  input wire logic serial_tx_line,
  output logic serial_rx_line,
  output logic clear_to_send_in_n,
  output logic set_ready_in_n,
  output logic ring_in_n,
  output logic carrier_detect_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] d1_q, d2_q, d3_q; // Reply delay line
  // Idle lines high at time zero
  initial begin
    {d1_q, d2_q, d3_q} = 12'h000;
    {serial_rx_line, carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_to_send_in_n} = 5'h1F;
  end
  // Lines follow after two or four cycles, active low
  always @(posedge pclk) begin
    d1_q <= lines;
    d2_q <= d1_q;
    d3_q <= d2_q;
    {carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_to_send_in_n} <= ~(slow ? d3_q : d1_q);
    serial_rx_line <= serial_tx_line;
  end
endmodule : umls_modem

// ### bench/umls_top_tb.sv
// Self-checking bench for the modem control, line status and baud block.
// Assumes umls_top, the modem model and the bound checker are compiled.
module umls_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, divisor_access_bit, ier_line_en, ier_modem_en;
  logic core_irq, tx_shift_out, slow, pready, pslverr, rx_shift_in, serial_tx_line, serial_rx_line;
  logic terminal_ready_out_n, send_request_out_n, uart_irq, uart_irq_oe, line_status_irq;
  logic modem_status_irq, baud_tick, baud_out, clear_to_send_in_n, set_ready_in_n, ring_in_n;
  logic carrier_detect_in_n, b7, err;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0] lines, evt, le, lv, dl, ln; // Model state of status bits
  logic [7:0] ctl, v;
  logic [31:0] bad [5] = '{32'h8, 32'hC, 32'h0, 32'h11, 32'h40};
  logic [7:0] dvs [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0B, 8'hC8};
  umls_pkg::umls_rx_err_t rx_err;
  umls_pkg::umls_core_t core_st;
  int failures, comparisons, seed, n, k, m, h;

  umls_top umls_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .divisor_access_bit, .ier_line_en, .ier_modem_en, .core_irq, .rx_err,
    .core_st, .tx_shift_out, .rx_shift_in, .serial_rx_line, .serial_tx_line, .clear_to_send_in_n,
    .set_ready_in_n, .ring_in_n, .carrier_detect_in_n, .terminal_ready_out_n,
    .send_request_out_n, .uart_irq, .uart_irq_oe, .line_status_irq, .modem_status_irq,
    .baud_tick, .baud_out);
  umls_modem umls_modem_inst (.pclk, .lines, .slow, .serial_tx_line, .serial_rx_line,
    .clear_to_send_in_n, .set_ready_in_n, .ring_in_n, .carrier_detect_in_n);

  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    conclude;
  end
  // Random transmit shift data, mark during reset
  always @(posedge pclk) tx_shift_out <= presetn ? 1'($random(seed)) : 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // One APB transfer; evt is pulsed on the receiver events in the access cycle
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    int c;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    rx_err <= evt;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 16);
    if (c == 16) failures++;
    if (c == 16) conclude;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    rx_err <= 4'h0;
    @(posedge pclk);
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask : rd

  // Modem status model: effective levels and change bits
  task automatic upd;
    logic [3:0] e;
    e = ctl[4] ? {ctl[3], ctl[2], ctl[0], ctl[1]} : ln;
    dl |= ((lv ^ e) & 4'hB) | {1'b0, lv[2] & ~e[2], 2'h0};
    lv = e;
    repeat (10) @(posedge pclk);
  endtask : upd

  task automatic setc(input logic [7:0] x);
    bus(1'b1, 32'h10, x);
    ctl = x;
    upd;
  endtask : setc

  task automatic rdm;
    rd(32'h18, {24'h0, lv, dl});
    dl = 4'h0;
  endtask : rdm

  // Line status model: sticky errors, FIFO error bit, core levels
  task automatic rdl;
    b7 |= core_st.fifo_mode & core_st.fifo_err_any;
    rd(32'h14, {24'h0, b7 & core_st.fifo_mode, core_st.tx_hold_empty & core_st.tx_shift_empty,
      core_st.tx_hold_empty, le, ~core_st.rx_empty});
    le = {evt[0], evt[1], evt[2], evt[3]};
    if (!core_st.fifo_err_any) b7 = 1'b0;
    evt = 4'h0;
  endtask : rdl

  task automatic pulse(input logic [3:0] e);
    rx_err <= e;
    @(posedge pclk);
    rx_err <= 4'h0;
    le |= {e[0], e[1], e[2], e[3]};
    b7 |= core_st.fifo_mode & (|e[2:0]);
    repeat (3) @(posedge pclk);
    chk(line_status_irq, le != 4'h0);
    chk(uart_irq, (le != 4'h0) || (dl != 4'h0));
  endtask : pulse

  initial begin
    seed = 32'h82304964;
    {presetn, psel, penable, pwrite, divisor_access_bit, ier_line_en, ier_modem_en} = 7'h0;
    {core_irq, slow, b7, paddr, pwdata} = 67'h0;
    {lines, ln, lv, dl, le, evt, ctl} = 32'h0;
    rx_err = 4'h0;
    core_st = 5'h0B;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state and refused places
    rd(32'h10, 32'h0);
    rd(32'h1C, 32'h0);
    rdm;
    rdl;
    for (k = 0; k < 5; k++) begin
      rd(bad[k], 32'h0);
      chk(err, 32'h1);
    end
    bus(1'b1, 32'h14, 8'hFF);
    rdl;
    repeat (4) begin
      v = 8'($random(seed));
      bus(1'b1, 32'h1C, v);
      rd(32'h1C, {24'h0, v});
    end
    // Control, pins, loopback and modem status
    ier_modem_en <= 1'b1;
    for (k = 0; k < 8; k++) begin
      slow <= k[0];
      v = 8'($random(seed));
      setc(v);
      rd(32'h10, {27'h0, v[4:0]});
      chk({terminal_ready_out_n, send_request_out_n}, {v[4] | ~v[0], v[4] | ~v[1]});
      chk(uart_irq_oe, v[3]);
      ln = 4'($random(seed));
      lines <= ln;
      upd;
      chk(modem_status_irq, dl != 4'h0);
      rdm;
    end
    setc(8'h00);
    rdm;
    for (k = 0; k < 2; k++) begin
      ln = k[0] ? 4'h0 : 4'h4;
      lines <= ln;
      upd;
      rdm;
    end
    setc(8'h18);
    core_irq <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(uart_irq, 32'h1);
    core_irq <= 1'b0;
    setc(8'h00);
    // Line status errors, FIFO error bit, read race
    ier_line_en <= 1'b1;
    for (k = 0; k < 8; k++) begin
      core_st <= 5'($random(seed)) & 5'h1B;
      pulse(4'h1 << k[1:0]);
      rdl;
      rdl;
    end
    core_st <= 5'h16;
    repeat (2) @(posedge pclk);
    rdl;
    rdl;
    core_st <= 5'h12;
    repeat (2) @(posedge pclk);
    rdl;
    rdl;
    evt = 4'h8;
    rdl;
    rdl;
    // Baud generator: reload, period and duty
    divisor_access_bit <= 1'b1;
    bus(1'b1, 32'h0, 8'hFF);
    bus(1'b1, 32'h4, 8'hFF);
    for (k = 0; k < 6; k++) begin
      bus(1'b1, 32'h4, 8'h00);
      bus(1'b1, 32'h0, dvs[k]);
      rd(32'h0, {24'h0, dvs[k]});
      m = (dvs[k] == 8'h00) ? 3 : int'(dvs[k]);
      for (n = 0; n < m + 8 && baud_tick !== 1'b1; n++) @(posedge pclk);
      chk(n < m + 8, 32'h1);
      if (n >= m + 8) conclude;
      @(posedge pclk);
      h = int'(baud_out);
      for (n = 1; n < 300 && baud_tick !== 1'b1; n++) begin
        @(posedge pclk);
        h += int'(baud_out);
      end
      chk(n, m);
      if (n == 300) conclude;
      if (m > 1) chk(h, (m > 2) ? m - 2 : 1);
    end
    rd(32'h4, 32'h0);
    divisor_access_bit <= 1'b0;
    conclude;
  end
endmodule : umls_top_tb
